//--- src/acp_pkg.sv
// Shared constants for the array counter and 8-bit PWM block
package acp_pkg;
	// Module count and widths
	localparam int ACP_NUM_MOD = 2;
	localparam int ACP_AW = 8;
	// Register byte addresses
	localparam logic [7:0] ACP_ADDR_CNT_LOW = 8'h00;
	localparam logic [7:0] ACP_ADDR_CNT_HIGH = 8'h04;
	localparam logic [7:0] ACP_ADDR_MODE = 8'h08;
	localparam logic [7:0] ACP_ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ACP_CH_BASE = 8'h10;
	localparam logic [7:0] ACP_CH_STRIDE = 8'h10;
	localparam logic [7:0] ACP_CH_MODE = 8'h00;
	localparam logic [7:0] ACP_CH_CPL = 8'h04;
	localparam logic [7:0] ACP_CH_CPH = 8'h08;
	// Field positions
	localparam int ACP_MODE_ECF = 0;
	localparam int ACP_MODE_TSEL_LO = 1;
	localparam int ACP_MODE_IDLE = 7;
	localparam int ACP_STAT_OVF = 0;
	localparam int ACP_CHM_PWM = 1;
	localparam int ACP_CHM_ECOM = 6;
	// Timebase select encodings
	localparam logic [2:0] ACP_TB_DIV12 = 3'h0;
	localparam logic [2:0] ACP_TB_DIV4 = 3'h1;
	localparam logic [2:0] ACP_TB_T0 = 3'h2;
	localparam logic [2:0] ACP_TB_EXT = 3'h3;
	localparam logic [2:0] ACP_TB_SYS = 3'h4;
	localparam logic [2:0] ACP_TB_OSC8 = 3'h5;
	// Divider terminal counts
	localparam logic [3:0] ACP_DIV12_LAST = 4'hB;
	localparam logic [1:0] ACP_DIV4_LAST = 2'h3;
	localparam logic [2:0] ACP_OSC_LAST = 3'h7;
	// Counter limits and reset values
	localparam logic [15:0] ACP_CNT_MAX = 16'hFFFF;
	localparam logic [7:0] ACP_LOW_MAX = 8'hFF;
	localparam logic [7:0] ACP_BYTE_RST = 8'h00;
	localparam logic [15:0] ACP_CNT_RST = 16'h0000;
	localparam logic [15:0] ACP_CNT_ONE = 16'h0001;
	localparam logic [31:0] ACP_RD_ZERO = 32'h0000_0000;
endpackage

//--- src/acp_timebase.sv
// Count source selection and dividers for the array counter
`timescale 1ns/1ps
`default_nettype none
module acp_timebase
	import acp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] sel,
	input wire logic ext_s,
	input wire logic osc_s,
	input wire logic t0_ovf,
	output logic tick
);
	logic [3:0] div12_q;
	logic [1:0] div4_q;
	logic [2:0] osc_cnt_q;
	logic ext_prev_q;
	logic osc_prev_q;
	logic osc_rise;
	logic ext_fall;

	// Free running system clock dividers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div12_q <= '0;
			div4_q <= '0;
		end else begin
			div12_q <= (div12_q == ACP_DIV12_LAST) ? '0 : div12_q + 4'h1;
			div4_q <= div4_q + 2'h1;
		end
	end

	// Edge history of the synchronised pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_prev_q <= 1'b0;
			osc_prev_q <= 1'b0;
			osc_cnt_q <= '0;
		end else begin
			ext_prev_q <= ext_s;
			osc_prev_q <= osc_s;
			if (osc_rise) begin
				osc_cnt_q <= osc_cnt_q + 3'h1;
			end
		end
	end

	assign ext_fall = ext_prev_q & ~ext_s;
	assign osc_rise = osc_s & ~osc_prev_q;

	// Source multiplexer, reserved codes never count
	always_comb begin
		case (sel)
			ACP_TB_DIV12: tick = (div12_q == ACP_DIV12_LAST);
			ACP_TB_DIV4: tick = (div4_q == ACP_DIV4_LAST);
			ACP_TB_T0: tick = t0_ovf;
			ACP_TB_EXT: tick = ext_fall;
			ACP_TB_SYS: tick = 1'b1;
			ACP_TB_OSC8: tick = osc_rise && (osc_cnt_q == ACP_OSC_LAST);
			default: tick = 1'b0;
		endcase
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_div4;
		(sel == ACP_TB_DIV4) && tick && $stable(sel) ##1 $stable(sel) |-> !tick;
	endproperty
	a_div4: assert property (p_div4) else $error("divide by four ticked twice");

	property p_ext;
		(sel == ACP_TB_EXT) && ext_prev_q && !ext_s |-> tick;
	endproperty
	a_ext: assert property (p_ext) else $error("falling edge not counted");
endmodule
`default_nettype wire

//--- src/acp_pwm_chan.sv
// One capture/compare module in 8-bit PWM mode
`timescale 1ns/1ps
`default_nettype none
module acp_pwm_chan
	import acp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pwm_mode,
	input wire logic [7:0] cnt_low,
	input wire logic [7:0] cmp_low,
	input wire logic low_wrap,
	output logic pin_q
);
	// Set on compare match, clear on low byte overflow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_q <= 1'b0;
		end else if (!pwm_mode) begin
			pin_q <= 1'b0;
		end else if (low_wrap) begin
			pin_q <= 1'b0;
		end else if (cnt_low == cmp_low) begin
			pin_q <= 1'b1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_off_low;
		!pwm_mode |=> !pin_q;
	endproperty
	a_off_low: assert property (p_off_low) else $error("pin high outside PWM mode");

	property p_wrap_low;
		pwm_mode && low_wrap |=> !pin_q;
	endproperty
	a_wrap_low: assert property (p_wrap_low) else $error("pin not low after overflow");

	property p_match_high;
		pwm_mode && !low_wrap && (cnt_low == cmp_low) |=> pin_q;
	endproperty
	a_match_high: assert property (p_match_high) else $error("pin not high on match");
endmodule
`default_nettype wire

//--- src/acp_top.sv
// Array counter/timer with 8-bit PWM modules behind an APB slave
// Function
// - Sixteen-bit up-counter seen by software as a high and a low byte.
// - Reading low byte snapshots high byte; next high read returns snapshot.
// - Reading counter bytes never disturbs counting.
// - Timebase select picks div12, div4, timer0, external edge, clock, osc/8.
// - External input counts falling edges; source at most a quarter clock rate.
// - Oscillator divided by eight is synchronised before advancing counter.
// - Wrap from all ones to zero sets the overflow flag.
// - Overflow raises interrupt only while overflow interrupt enable is set.
// - Overflow flag is never cleared by hardware; software clears it.
// - With idle halt clear, counting continues during CPU idle.
// - Each module makes its own PWM output from the shared counter.
// - PWM mode needs both compare enable and PWM select set.
// - Output goes high when low counter byte equals compare low byte.
// - Output goes low when low counter byte overflows.
// - Low byte wrap reloads compare low byte from counter high byte.
// - Duty is 256 minus compare high byte, over 256; the reload here takes the counter high byte, so compare high is unused.
// - Clearing compare enable gives a constantly low output.
// - Writing compare low clears compare enable; compare high sets it.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module acp_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [acp_pkg::ACP_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_count_input,
	input wire logic ext_osc_in,
	input wire logic timer0_overflow,
	input wire logic cpu_idle,
	output logic [acp_pkg::ACP_NUM_MOD-1:0] module_output_pin,
	output logic overflow_irq
);
	import acp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [1:0] ext_sync_q;
	logic [1:0] osc_sync_q;
	logic tick;
	logic run;
	logic cnt_en;
	logic low_wrap;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic [7:0] cnt_high;
	logic [7:0] snap_q;
	logic ovf_q;
	logic ovf_irq_en_q;
	logic [2:0] tsel_q;
	logic idle_halt_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_d;
	logic hit_d;
	logic setup;
	logic acc;
	logic wr;
	logic rd;
	logic wr_low;
	logic wr_high;
	logic wr_mode;
	logic wr_stat;
	logic [ACP_NUM_MOD-1:0] ecom_q;
	logic [ACP_NUM_MOD-1:0] pwm_sel_q;
	logic [7:0] cpl_q [ACP_NUM_MOD];
	logic [7:0] cph_q [ACP_NUM_MOD];
	logic [ACP_NUM_MOD-1:0] ch_wr_mode;
	logic [ACP_NUM_MOD-1:0] ch_wr_cpl;
	logic [ACP_NUM_MOD-1:0] ch_wr_cph;
	logic [ACP_NUM_MOD-1:0] pin_q;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	// Two flops for each asynchronous input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync_q <= 2'h0;
			osc_sync_q <= 2'h0;
		end else begin
			ext_sync_q <= {ext_sync_q[0], external_count_input};
			osc_sync_q <= {osc_sync_q[0], ext_osc_in};
		end
	end

	// Count source selection
	acp_timebase u_timebase (
		.pclk(pclk),
		.presetn(presetn),
		.sel(tsel_q),
		.ext_s(ext_sync_q[1]),
		.osc_s(osc_sync_q[1]),
		.t0_ovf(timer0_overflow),
		.tick(tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB access decode

	assign setup = psel && !penable;
	assign acc = psel && penable && pready_q;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign wr_low = wr && (paddr == ACP_ADDR_CNT_LOW);
	assign wr_high = wr && (paddr == ACP_ADDR_CNT_HIGH);
	assign wr_mode = wr && (paddr == ACP_ADDR_MODE);
	assign wr_stat = wr && (paddr == ACP_ADDR_STATUS);

	// Read data and address hit for the pending transfer
	always_comb begin
		rd_d = ACP_RD_ZERO;
		hit_d = 1'b1;
		if (paddr == ACP_ADDR_CNT_LOW) begin
			rd_d[7:0] = cnt_q[7:0];
		end else if (paddr == ACP_ADDR_CNT_HIGH) begin
			rd_d[7:0] = snap_q;
		end else if (paddr == ACP_ADDR_MODE) begin
			rd_d[ACP_MODE_ECF] = ovf_irq_en_q;
			rd_d[ACP_MODE_TSEL_LO +: 3] = tsel_q;
			rd_d[ACP_MODE_IDLE] = idle_halt_q;
		end else if (paddr == ACP_ADDR_STATUS) begin
			rd_d[ACP_STAT_OVF] = ovf_q;
		end else begin
			hit_d = 1'b0;
		end
		for (int n = 0; n < ACP_NUM_MOD; n++) begin
			if (paddr == ACP_CH_BASE + ACP_CH_STRIDE * 8'(n) + ACP_CH_MODE) begin
				rd_d[ACP_CHM_ECOM] = ecom_q[n];
				rd_d[ACP_CHM_PWM] = pwm_sel_q[n];
				hit_d = 1'b1;
			end else if (paddr == ACP_CH_BASE + ACP_CH_STRIDE * 8'(n) + ACP_CH_CPL) begin
				rd_d[7:0] = cpl_q[n];
				hit_d = 1'b1;
			end else if (paddr == ACP_CH_BASE + ACP_CH_STRIDE * 8'(n) + ACP_CH_CPH) begin
				rd_d[7:0] = cph_q[n];
				hit_d = 1'b1;
			end
		end
	end

	// No wait state: answer prepared in setup, given in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= ACP_RD_ZERO;
		end else if (setup) begin
			pready_q <= 1'b1;
			pslverr_q <= !hit_d;
			prdata_q <= pwrite ? ACP_RD_ZERO : rd_d;
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Array mode register

	// Timebase, interrupt enable and idle behaviour
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_irq_en_q <= 1'b0;
			tsel_q <= ACP_TB_DIV12;
			idle_halt_q <= 1'b0;
		end else if (wr_mode) begin
			ovf_irq_en_q <= pwdata[ACP_MODE_ECF];
			tsel_q <= pwdata[ACP_MODE_TSEL_LO +: 3];
			idle_halt_q <= pwdata[ACP_MODE_IDLE];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter

	assign run = !(idle_halt_q && cpu_idle);
	assign cnt_en = tick && run;
	assign cnt_high = cnt_q[15:8];
	assign low_wrap = cnt_en && !wr_low && (cnt_q[7:0] == ACP_LOW_MAX);

	// Software byte writes win over a count in the same cycle
	always_comb begin
		cnt_d = cnt_q;
		if (cnt_en) begin
			cnt_d = cnt_q + ACP_CNT_ONE;
		end
		if (wr_low) begin
			cnt_d[7:0] = pwdata[7:0];
		end
		if (wr_high) begin
			cnt_d[15:8] = pwdata[7:0];
		end
	end

	// Counter state, reads have no part here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= ACP_CNT_RST;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// High byte snapshot, taken at the edge that captures the low byte read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snap_q <= ACP_BYTE_RST;
		end else if (setup && !pwrite && (paddr == ACP_ADDR_CNT_LOW)) begin
			snap_q <= cnt_high;
		end
	end

	// Overflow flag: hardware set wins over a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_q <= 1'b0;
		end else if (cnt_en && !wr_low && !wr_high && (cnt_q == ACP_CNT_MAX)) begin
			ovf_q <= 1'b1;
		end else if (wr_stat) begin
			ovf_q <= pwdata[ACP_STAT_OVF];
		end
	end

	// Interrupt request gated by its enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_irq <= 1'b0;
		end else begin
			overflow_irq <= ovf_q && ovf_irq_en_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Capture/compare modules

	genvar g;
	generate
		for (g = 0; g < ACP_NUM_MOD; g++) begin : g_mod
			assign ch_wr_mode[g] = wr && (paddr == ACP_CH_BASE + ACP_CH_STRIDE * 8'(g) + ACP_CH_MODE);
			assign ch_wr_cpl[g] = wr && (paddr == ACP_CH_BASE + ACP_CH_STRIDE * 8'(g) + ACP_CH_CPL);
			assign ch_wr_cph[g] = wr && (paddr == ACP_CH_BASE + ACP_CH_STRIDE * 8'(g) + ACP_CH_CPH);

			// Mode bits with compare enable side effects of byte writes
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ecom_q[g] <= 1'b0;
					pwm_sel_q[g] <= 1'b0;
				end else if (ch_wr_cpl[g]) begin
					ecom_q[g] <= 1'b0;
				end else if (ch_wr_cph[g]) begin
					ecom_q[g] <= 1'b1;
				end else if (ch_wr_mode[g]) begin
					ecom_q[g] <= pwdata[ACP_CHM_ECOM];
					pwm_sel_q[g] <= pwdata[ACP_CHM_PWM];
				end
			end

			// Compare bytes; a software write beats the automatic reload
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cpl_q[g] <= ACP_BYTE_RST;
					cph_q[g] <= ACP_BYTE_RST;
				end else begin
					if (ch_wr_cpl[g]) begin
						cpl_q[g] <= pwdata[7:0];
					end else if (low_wrap) begin
						cpl_q[g] <= cnt_high;
					end
					if (ch_wr_cph[g]) begin
						cph_q[g] <= pwdata[7:0];
					end
				end
			end

			// Independent waveform per module
			acp_pwm_chan u_chan (
				.pclk(pclk),
				.presetn(presetn),
				.pwm_mode(ecom_q[g] && pwm_sel_q[g]),
				.cnt_low(cnt_q[7:0]),
				.cmp_low(cpl_q[g]),
				.low_wrap(low_wrap),
				.pin_q(pin_q[g])
			);
		end
	endgenerate

	assign module_output_pin = pin_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_snap;
		setup && !pwrite && (paddr == ACP_ADDR_CNT_LOW) |=> (snap_q == $past(cnt_high)) && (prdata_q[7:0] == $past(cnt_q[7:0]));
	endproperty
	a_snap: assert property (p_snap) else $error("snapshot not coherent with low byte");
	property p_count;
		cnt_en && !wr_low && !wr_high |=> cnt_q == $past(cnt_q) + ACP_CNT_ONE;
	endproperty
	a_count: assert property (p_count) else $error("counter did not advance");
	property p_read_free;
		rd && !cnt_en |=> $stable(cnt_q);
	endproperty
	a_read_free: assert property (p_read_free) else $error("read disturbed counter");
	property p_ovf_set;
		cnt_en && !wr_low && !wr_high && (cnt_q == ACP_CNT_MAX) |=> ovf_q && (cnt_q == ACP_CNT_RST);
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");
	property p_ovf_hold;
		ovf_q && !wr_stat |=> ovf_q;
	endproperty
	a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost");
	sequence s_flag_enabled;
		ovf_q && ovf_irq_en_q;
	endsequence
	property p_irq;
		s_flag_enabled |=> overflow_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");
	property p_irq_masked;
		!ovf_irq_en_q |=> !overflow_irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt raised");
	property p_idle_halt;
		idle_halt_q && cpu_idle && !wr_low && !wr_high |=> $stable(cnt_q);
	endproperty
	a_idle_halt: assert property (p_idle_halt) else $error("counted while halted");
	property p_idle_run;
		!idle_halt_q && cpu_idle && tick && !wr_low && !wr_high |=> !$stable(cnt_q);
	endproperty
	a_idle_run: assert property (p_idle_run) else $error("stopped in idle");
	property p_cpl_clr;
		ch_wr_cpl[0] |=> !ecom_q[0] ##1 !module_output_pin[0];
	endproperty
	a_cpl_clr: assert property (p_cpl_clr) else $error("compare enable not cleared");
	property p_cph_set;
		ch_wr_cph[0] |=> ecom_q[0];
	endproperty
	a_cph_set: assert property (p_cph_set) else $error("compare enable not set");
	property p_reload;
		low_wrap && !ch_wr_cpl[0] |=> cpl_q[0] == $past(cnt_high);
	endproperty
	a_reload: assert property (p_reload) else $error("compare low not reloaded");
endmodule
`default_nettype wire

//--- sim/acp_partner.sv
// Far-side sources: external count input, oscillator and timer 0 overflow
`timescale 1ns/1ps
`default_nettype none
module acp_partner (
	input wire logic pclk,
	output logic ext_cnt,
	output logic osc,
	output logic t0_pulse
);
	logic [2:0] ext_q = 3'h0;
	logic [2:0] t0_q = 3'h0;
	// Oscillator on its own period, unrelated to pclk
	initial begin
		osc = 1'b0;
		forever #23 osc = ~osc;
	end
	// Phase counters for the edge source and the timer pulse
	always @(posedge pclk) begin
		ext_q <= ext_q + 3'h1;
		t0_q <= (t0_q == 3'h4) ? 3'h0 : t0_q + 3'h1;
	end
	// One falling edge every 8 cycles, slower than a quarter clock
	assign ext_cnt = ext_q[2];
	// Timer 0 overflow pulse every 5 cycles
	assign t0_pulse = (t0_q == 3'h0);
endmodule
`default_nettype wire

//--- sim/array_counter_pwm8_bench.sv
// Self-checking bench for the array counter and PWM block
`timescale 1ns/1ps
`default_nettype none
module array_counter_pwm8_bench;
	import acp_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_ci, osc, t0, cpu_idle, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, lo;
	logic [1:0] pins;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	int t_done, t1, n, h, hi0, hi1;
	acp_top acp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_count_input(ext_ci), .ext_osc_in(osc), .timer0_overflow(t0), .cpu_idle(cpu_idle),
		.module_output_pin(pins), .overflow_irq(irq));
	acp_partner acp_partner_inst (.pclk(pclk), .ext_cnt(ext_ci), .osc(osc), .t0_pulse(t0));
	////////////////////////////////////////////////////////////////////////////////
	// Clock and cycle count
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	////////////////////////////////////////////////////////////////////////////////
	// Verdict and comparisons
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic near(input string nm, input logic [31:0] seen, input int exp, input int tol);
		chk(nm, (seen + tol >= exp && seen <= exp + tol) ? exp : seen, exp);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// APB master: setup, access until pready, then release
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Request held until the rising edge that samples pready high
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			n_fail++;
			$display("Error pready expected 1 seen 0");
			test_done();
		end
		rd = prdata;
		err = pslverr;
		t_done = cyc;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	function automatic logic [7:0] ch(input int m, input logic [7:0] off);
		return ACP_CH_BASE + ACP_CH_STRIDE * m[7:0] + off;
	endfunction
	// Expected counts for a run of so many cycles on a timebase
	function automatic int ticks(input logic [2:0] code, input int cycles);
		int per;
		case (code)
			ACP_TB_DIV12: per = 12;
			ACP_TB_DIV4: per = 4;
			ACP_TB_T0: per = 5;
			ACP_TB_EXT: per = 8;
			ACP_TB_SYS: per = 1;
			default: per = 0;
		endcase
		if (code == ACP_TB_OSC8) return cycles * 20 / 368;
		return (per == 0) ? 0 : cycles / per;
	endfunction
	// Run the counter from zero for a random time, then read it coherently
	task automatic measure(input logic [2:0] code, input logic halt, input logic idle);
		cpu_idle <= idle;
		wr(ACP_ADDR_MODE, 32'h0C);
		wr(ACP_ADDR_CNT_LOW, 32'h0);
		wr(ACP_ADDR_CNT_HIGH, 32'h0);
		wr(ACP_ADDR_MODE, {24'h0, halt, 3'h0, code, 1'b0});
		t1 = t_done;
		repeat (200 + $urandom % 400) @(posedge pclk);
		wr(ACP_ADDR_MODE, 32'h0C);
		t1 = t_done - t1;
		rdc(ACP_ADDR_CNT_LOW);
		lo = rd;
		rdc(ACP_ADDR_CNT_HIGH);
		near("count", {16'h0, rd[7:0], lo[7:0]}, (halt && idle) ? 0 : ticks(code, t1), 2);
		cpu_idle <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cpu_idle = 1'b0;
		n = $urandom(41);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("pins", pins, 0);
		chk("irq", irq, 0);
		rdc(ACP_ADDR_MODE);
		chk("mode", rd, 0);
		rdc(ACP_ADDR_STATUS);
		chk("status", rd, 0);
		wr(8'hF0, 32'hFF);
		chk("slverr", err, 1);
		rdc(8'hF0);
		chk("slverr", err, 1);
		chk("unmapped", rd, 0);
		$display("Reset and map test done");
		// Every timebase code, then idle halting
		for (n = 0; n < 8; n++) measure(n[2:0], 1'b0, 1'b0);
		measure(ACP_TB_SYS, 1'b0, 1'b1);
		measure(ACP_TB_SYS, 1'b1, 1'b1);
		measure(ACP_TB_SYS, 1'b1, 1'b0);
		$display("Timebase test done");
		// Snapshot of the high byte across a low byte wrap
		wr(ACP_ADDR_CNT_HIGH, 32'h12);
		wr(ACP_ADDR_CNT_LOW, 32'hF0);
		wr(ACP_ADDR_MODE, 32'h08);
		rdc(ACP_ADDR_CNT_LOW);
		repeat (40) @(posedge pclk);
		rdc(ACP_ADDR_CNT_HIGH);
		chk("snapshot", rd, 32'h12);
		rdc(ACP_ADDR_CNT_LOW);
		rdc(ACP_ADDR_CNT_HIGH);
		chk("high after", rd, 32'h13);
		// Low byte read right at its wrap must pair with the old high byte
		wr(ACP_ADDR_MODE, 32'h0C);
		wr(ACP_ADDR_CNT_HIGH, 32'h34);
		wr(ACP_ADDR_CNT_LOW, 32'hFE);
		wr(ACP_ADDR_MODE, 32'h08);
		rdc(ACP_ADDR_CNT_LOW);
		lo = rd;
		rdc(ACP_ADDR_CNT_HIGH);
		near("coherent", {16'h0, rd[7:0], lo[7:0]}, 32'h3500, 4);
		$display("Snapshot test done");
		// Overflow flag, interrupt enable and software clear
		wr(ACP_ADDR_MODE, 32'h0C);
		wr(ACP_ADDR_STATUS, 32'h0);
		wr(ACP_ADDR_CNT_HIGH, 32'hFF);
		wr(ACP_ADDR_CNT_LOW, 32'hFD);
		wr(ACP_ADDR_MODE, 32'h09);
		// Let the wrap happen before the status is captured
		repeat (4) @(posedge pclk);
		rdc(ACP_ADDR_STATUS);
		chk("flag", rd[ACP_STAT_OVF], 1);
		chk("irq", irq, 1);
		wr(ACP_ADDR_MODE, 32'h0C);
		// Request flop follows the enable one edge later
		@(posedge pclk);
		chk("irq", irq, 0);
		rdc(ACP_ADDR_STATUS);
		chk("flag", rd[ACP_STAT_OVF], 1);
		wr(ACP_ADDR_MODE, 32'h0D);
		@(posedge pclk);
		chk("irq", irq, 1);
		wr(ACP_ADDR_STATUS, 32'h0);
		rdc(ACP_ADDR_STATUS);
		chk("flag", rd[ACP_STAT_OVF], 0);
		chk("irq", irq, 0);
		$display("Overflow test done");
		// PWM on one module while the other lacks compare enable
		for (n = 0; n < 2; n++) begin
			h = 16 + $urandom % 200;
			wr(ACP_ADDR_MODE, 32'h0C);
			wr(ch(n, ACP_CH_CPL), h);
			rdc(ch(n, ACP_CH_MODE));
			chk("ecom", rd[ACP_CHM_ECOM], 0);
			wr(ch(n, ACP_CH_CPH), h);
			rdc(ch(n, ACP_CH_MODE));
			chk("ecom", rd[ACP_CHM_ECOM], 1);
			wr(ch(n, ACP_CH_MODE), 32'h42);
			wr(ch(1 - n, ACP_CH_CPL), 32'h0);
			wr(ch(1 - n, ACP_CH_MODE), 32'h02);
			wr(ACP_ADDR_CNT_HIGH, h);
			wr(ACP_ADDR_CNT_LOW, 32'hFF);
			wr(ACP_ADDR_MODE, 32'h08);
			hi0 = 0;
			hi1 = 0;
			repeat (256) begin
				@(negedge pclk);
				hi0 += (pins[n] === 1'b1);
				hi1 += (pins[1 - n] === 1'b1);
			end
			@(posedge pclk);
			near("pwm high", hi0, 255 - h, 3);
			chk("pwm off", hi1, 0);
		end
		$display("PWM test done");
		test_done();
	end
endmodule
`default_nettype wire
